// ### ieee_status_pkg.sv
// constants, codes and text tables for the status and queue block
// assumes a command decoder ahead of it that hands over parsed commands
package ieee_status_pkg;
  // command codes from the decoder
  localparam logic [2:0] OP_ENAB_WR = 3'h0;
  localparam logic [2:0] OP_ENAB_RD = 3'h1;
  localparam logic [2:0] OP_ESR_RD = 3'h2;
  localparam logic [2:0] OP_CLS = 3'h3;
  localparam logic [2:0] OP_ERR_RD = 3'h4;
  // event register bits
  localparam int EV_QRY = 2;
  localparam int EV_DEV = 3;
  localparam int EV_EXE = 4;
  localparam int EV_CMD = 5;
  // status byte bits
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam logic [7:0] ENAB_RST = 8'h00;
  localparam logic [7:0] ESR_RST = 8'h00;
  localparam int ENAB_MAX = 255;
  localparam int ERRQ_DEPTH = 20;
  localparam int OUTQ_DEPTH = 16;
  localparam int OUTQ_WIDTH = 8;
  localparam int ERR_ID_W = 3;
  // error entry ids
  localparam logic [2:0] ID_NOERR = 3'h0;
  localparam logic [2:0] ID_CMD = 3'h1;
  localparam logic [2:0] ID_EXE = 3'h2;
  localparam logic [2:0] ID_RANGE = 3'h3;
  localparam logic [2:0] ID_DEV = 3'h4;
  localparam logic [2:0] ID_OVF = 3'h5;
  localparam logic [2:0] ID_QRY = 3'h6;
  // ascii
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam int TXT_W = 8 * 21;

  function automatic logic [9:0] err_mag(input logic [2:0] id);
    case (id)
      ID_CMD: err_mag = 10'd100;
      ID_EXE: err_mag = 10'd200;
      ID_RANGE: err_mag = 10'd222;
      ID_DEV: err_mag = 10'd300;
      ID_OVF: err_mag = 10'd350;
      ID_QRY: err_mag = 10'd400;
      default: err_mag = 10'd0;
    endcase
  endfunction

  function automatic logic [TXT_W-1:0] desc_text(input logic [2:0] id);
    case (id)
      ID_CMD: desc_text = TXT_W'("Command error");
      ID_EXE: desc_text = TXT_W'("Execution error");
      ID_RANGE: desc_text = TXT_W'("Data out of range");
      ID_DEV: desc_text = TXT_W'("Device-specific error");
      ID_OVF: desc_text = TXT_W'("Queue overflow");
      ID_QRY: desc_text = TXT_W'("Query error");
      default: desc_text = TXT_W'("No error");
    endcase
  endfunction

  function automatic logic [4:0] desc_len(input logic [2:0] id);
    case (id)
      ID_CMD: desc_len = 5'd13;
      ID_EXE: desc_len = 5'd15;
      ID_RANGE: desc_len = 5'd17;
      ID_DEV: desc_len = 5'd21;
      ID_OVF: desc_len = 5'd14;
      ID_QRY: desc_len = 5'd11;
      default: desc_len = 5'd8;
    endcase
  endfunction
endpackage

// ### byte_fifo.sv
// first-in first-out buffer of flip-flops with valid/ready on both sides
// assumes one clock, asynchronous active-high reset, enable freezes it
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and control
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in,
  output logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic do_wr, do_rd;

  assign in_ready_out = cnt_reg != FULL;
  assign out_valid_out = cnt_reg != '0;
  assign out_data_out = mem_reg[rd_reg];
  assign count_out = cnt_reg;

  always_comb begin
    do_wr = in_valid_in && in_ready_out;
    do_rd = out_valid_out && out_ready_in;
    wr_next = do_wr ? ((wr_reg == LAST) ? '0 : wr_reg + 1'b1) : wr_reg;
    rd_next = do_rd ? ((rd_reg == LAST) ? '0 : rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg + CW'(do_wr) - CW'(do_rd);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (en_in) begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (en_in && do_wr) begin
      mem_reg[wr_reg] <= in_data_in;
    end
  end

  fifo_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cnt_reg <= FULL) else $error("fifo count past depth");
  fifo_order_a: assert property (@(posedge clk_in) disable iff (rst_in)
    en_in && do_wr && !do_rd |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("fifo write not counted");
endmodule

// ### error_queue.sv
// error entry queue of flip-flops; a push into a full queue marks overflow
// assumes one clock, asynchronous active-high reset, enable freezes it
`timescale 1ns/1ps
module error_queue
  import ieee_status_pkg::*;
#(
  parameter int DEPTH = ERRQ_DEPTH
) (
  // clock and control
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  // push and pop
  input wire logic push_in,
  input wire logic [ERR_ID_W-1:0] push_id_in,
  input wire logic pop_in,
  output logic [ERR_ID_W-1:0] head_id_out,
  output logic empty_out,
  output logic full_out,
  output logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  logic [ERR_ID_W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next, newest;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic do_wr, do_rd, do_ovf;

  assign empty_out = cnt_reg == '0;
  assign full_out = cnt_reg == FULL;
  assign head_id_out = mem_reg[rd_reg];
  assign count_out = cnt_reg;

  always_comb begin
    do_rd = pop_in && !empty_out;
    do_wr = push_in && (!full_out || do_rd);
    do_ovf = push_in && full_out && !do_rd;
    newest = (wr_reg == '0) ? LAST : wr_reg - 1'b1;
    wr_next = do_wr ? ((wr_reg == LAST) ? '0 : wr_reg + 1'b1) : wr_reg;
    rd_next = do_rd ? ((rd_reg == LAST) ? '0 : rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg + CW'(do_wr) - CW'(do_rd);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (en_in) begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (en_in && do_wr) begin
      mem_reg[wr_reg] <= push_id_in;
    end else if (en_in && do_ovf) begin
      mem_reg[newest] <= ID_OVF;
    end
  end

  errq_ovf_a: assert property (@(posedge clk_in) disable iff (rst_in)
    en_in && do_ovf |=> mem_reg[$past(newest)] == ID_OVF && full_out)
    else $error("overflow entry not written");
  errq_depth_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cnt_reg <= FULL) else $error("error queue past depth");
endmodule

// ### ieee_status_event_queues.sv
// status reporting: event and enable registers, output and error queues
// assumes parsed commands and event pulses from a decoder; talker side
// hands bytes out with valid/ready standing in for the bus handshake
`timescale 1ns/1ps
module ieee_status_event_queues
  import ieee_status_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic CE_IN,
  // parsed commands
  input wire logic CMD_VALID_IN,
  input wire logic [2:0] CMD_OP_IN,
  input wire logic signed [31:0] CMD_ARG_IN,
  output logic CMD_READY_OUT,
  // event pulses and pending response
  input wire logic [7:0] EVT_SET_IN,
  input wire logic PENDING_IN,
  // talker byte stream
  input wire logic TALK_IN,
  output logic [7:0] TX_DATA_OUT,
  output logic TX_VALID_OUT,
  input wire logic TX_READY_IN,
  // status
  output logic [7:0] STB_OUT,
  output logic [7:0] ESR_OUT,
  output logic [7:0] ENAB_OUT
);
  typedef enum {F_IDLE, F_SIGN, F_DIG, F_COMMA, F_Q1, F_TEXT, F_Q2, F_EOL}
    fmt_e;
  localparam int QCW = $clog2(OUTQ_DEPTH + 1);
  localparam int ECW = $clog2(ERRQ_DEPTH + 1);

  logic [7:0] enab_reg, enab_next, esr_reg, esr_next, ev_set, rise;
  logic esb_reg, esb_next, armed_reg, armed_next;
  fmt_e fst_reg, fst_next;
  logic [9:0] fval_reg, fval_next;
  logic fneg_reg, fneg_next, ferr_reg, ferr_next;
  logic fgo_reg, fgo_next;
  logic [2:0] fid_reg, fid_next;
  logic [4:0] fidx_reg, fidx_next;
  logic take, clr, range_err, qerr;
  logic [7:0] wr_arg;
  logic push, q_ready, q_valid, q_pop;
  logic [7:0] push_byte;
  logic [3:0] digit;
  logic [TXT_W-1:0] text;
  logic [4:0] tlen;
  logic [QCW-1:0] q_count;
  logic e_push, e_pop, e_empty, e_full;
  logic [2:0] e_id, e_head;
  logic [ECW-1:0] e_count;

  assign take = CMD_VALID_IN && fst_reg == F_IDLE;
  assign CMD_READY_OUT = fst_reg == F_IDLE;
  assign wr_arg = CMD_ARG_IN[7:0];
  assign text = desc_text(fid_reg);
  assign tlen = desc_len(fid_reg);

  // event and enable registers
  always_comb begin
    range_err = take && CMD_OP_IN == OP_ENAB_WR &&
      (CMD_ARG_IN < 0 || CMD_ARG_IN > ENAB_MAX);
    clr = take && (CMD_OP_IN == OP_ESR_RD || CMD_OP_IN == OP_CLS);
    qerr = armed_reg && TALK_IN && !q_valid && fst_reg == F_IDLE &&
      !PENDING_IN && !CMD_VALID_IN;
    ev_set = EVT_SET_IN;
    ev_set[EV_EXE] = EVT_SET_IN[EV_EXE] | range_err;
    ev_set[EV_QRY] = EVT_SET_IN[EV_QRY] | qerr;
    esr_next = (clr ? ESR_RST : esr_reg) | ev_set;
    enab_next = enab_reg;
    if (take && CMD_OP_IN == OP_ENAB_WR && !range_err) begin
      enab_next = wr_arg;
    end
    esb_next = |(esr_next & enab_next);
    armed_next = TALK_IN ? (armed_reg && !qerr) : 1'b1;
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      enab_reg <= ENAB_RST;
      esr_reg <= ESR_RST;
      esb_reg <= 1'b0;
      armed_reg <= 1'b1;
    end else if (CE_IN) begin
      enab_reg <= enab_next;
      esr_reg <= esr_next;
      esb_reg <= esb_next;
      armed_reg <= armed_next;
    end
  end

  // one error entry per cycle on rising event bits, for the most severe bit only
  always_comb begin
    rise = ev_set & (~esr_reg | {8{clr}});
    e_push = 1'b1;
    if (rise[EV_CMD]) begin
      e_id = ID_CMD;
    end else if (rise[EV_EXE]) begin
      e_id = range_err ? ID_RANGE : ID_EXE;
    end else if (rise[EV_DEV]) begin
      e_id = ID_DEV;
    end else if (rise[EV_QRY]) begin
      e_id = ID_QRY;
    end else begin
      e_id = ID_NOERR;
      e_push = 1'b0;
    end
    e_pop = take && CMD_OP_IN == OP_ERR_RD;
  end

  error_queue #(
    .DEPTH(ERRQ_DEPTH)
  ) u_error_queue (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .en_in(CE_IN),
    .push_in(e_push),
    .push_id_in(e_id),
    .pop_in(e_pop),
    .head_id_out(e_head),
    .empty_out(e_empty),
    .full_out(e_full),
    .count_out(e_count)
  );

  // response formatter: sign for errors, decimal digits, then comma/quoted text for errors
  always_comb begin
    fst_next = fst_reg;
    fval_next = fval_reg;
    fneg_next = fneg_reg;
    ferr_next = ferr_reg;
    fgo_next = fgo_reg;
    fid_next = fid_reg;
    fidx_next = fidx_reg;
    push = 1'b0;
    push_byte = 8'h00;
    case (fidx_reg)
      5'd2: digit = 4'(fval_reg / 10'd100);
      5'd1: digit = 4'((fval_reg / 10'd10) % 10'd10);
      default: digit = 4'(fval_reg % 10'd10);
    endcase
    case (fst_reg)
      F_IDLE: begin
        fidx_next = 5'd2;
        fgo_next = 1'b0;
        ferr_next = 1'b0;
        fneg_next = 1'b0;
        if (take) begin
          case (CMD_OP_IN)
            OP_ENAB_RD: begin
              fval_next = {2'h0, enab_reg};
              fst_next = F_DIG;
            end
            OP_ESR_RD: begin
              fval_next = {2'h0, esr_reg};
              fst_next = F_DIG;
            end
            OP_ERR_RD: begin
              fid_next = e_empty ? ID_NOERR : e_head;
              fval_next = err_mag(fid_next);
              fneg_next = fid_next != ID_NOERR;
              ferr_next = 1'b1;
              fst_next = F_SIGN;
            end
            default: fst_next = F_IDLE;
          endcase
        end
      end
      F_SIGN: begin
        push = 1'b1;
        push_byte = fneg_reg ? CH_MINUS : CH_PLUS;
        if (q_ready) begin
          fst_next = F_DIG;
        end
      end
      F_DIG: begin
        if (digit == 4'h0 && !fgo_reg && fidx_reg != 5'd0) begin
          fidx_next = fidx_reg - 5'd1;
        end else begin
          push = 1'b1;
          push_byte = CH_0 + {4'h0, digit};
          if (q_ready) begin
            fgo_next = 1'b1;
            if (fidx_reg == 5'd0) begin
              fst_next = ferr_reg ? F_COMMA : F_EOL;
            end else begin
              fidx_next = fidx_reg - 5'd1;
            end
          end
        end
      end
      F_COMMA: begin
        push = 1'b1;
        push_byte = CH_COMMA;
        if (q_ready) begin
          fst_next = F_Q1;
        end
      end
      F_Q1: begin
        push = 1'b1;
        push_byte = CH_QUOTE;
        fidx_next = 5'd0;
        if (q_ready) begin
          fst_next = F_TEXT;
        end
      end
      F_TEXT: begin
        push = 1'b1;
        push_byte = text[8 * (tlen - fidx_reg - 5'd1) +: 8];
        if (q_ready) begin
          if (fidx_reg == tlen - 5'd1) begin
            fst_next = F_Q2;
          end else begin
            fidx_next = fidx_reg + 5'd1;
          end
        end
      end
      F_Q2: begin
        push = 1'b1;
        push_byte = CH_QUOTE;
        if (q_ready) begin
          fst_next = F_EOL;
        end
      end
      F_EOL: begin
        push = 1'b1;
        push_byte = CH_LF;
        if (q_ready) begin
          fst_next = F_IDLE;
        end
      end
      default: fst_next = F_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      fst_reg <= F_IDLE;
      fval_reg <= 10'h000;
      fneg_reg <= 1'b0;
      ferr_reg <= 1'b0;
      fgo_reg <= 1'b0;
      fid_reg <= ID_NOERR;
      fidx_reg <= 5'h00;
    end else if (CE_IN) begin
      fst_reg <= fst_next;
      fval_reg <= fval_next;
      fneg_reg <= fneg_next;
      ferr_reg <= ferr_next;
      fgo_reg <= fgo_next;
      fid_reg <= fid_next;
      fidx_reg <= fidx_next;
    end
  end

  // output queue; only an addressed talker drains it
  assign q_pop = TALK_IN && TX_READY_IN;
  assign TX_VALID_OUT = TALK_IN && q_valid;

  byte_fifo #(
    .WIDTH(OUTQ_WIDTH),
    .DEPTH(OUTQ_DEPTH)
  ) u_byte_fifo (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .en_in(CE_IN),
    .in_valid_in(push),
    .in_data_in(push_byte),
    .in_ready_out(q_ready),
    .out_valid_out(q_valid),
    .out_data_out(TX_DATA_OUT),
    .out_ready_in(q_pop),
    .count_out(q_count)
  );

  always_comb begin
    STB_OUT = 8'h00;
    STB_OUT[STB_MAV] = q_count != '0;
    STB_OUT[STB_ESB] = esb_reg;
  end
  assign ESR_OUT = esr_reg;
  assign ENAB_OUT = enab_reg;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  sequence enab_good_s;
    CE_IN && take && CMD_OP_IN == OP_ENAB_WR && !range_err;
  endsequence
  sequence esr_query_s;
    CE_IN && take && CMD_OP_IN == OP_ESR_RD && EVT_SET_IN == 8'h00;
  endsequence

  enab_load_a: assert property (enab_good_s |=> enab_reg == $past(wr_arg))
    else $error("enable write not loaded");
  enab_range_a: assert property (CE_IN && range_err |=>
    esr_reg[EV_EXE] && enab_reg == $past(enab_reg))
    else $error("bad enable argument accepted");
  esr_clear_a: assert property (esr_query_s |=> esr_reg == 8'h00)
    else $error("event register not cleared");
  esr_value_a: assert property (esr_query_s |=>
    fval_reg == {2'h0, $past(esr_reg)} && fst_reg == F_DIG)
    else $error("event query value wrong");
  esb_sum_a: assert property (STB_OUT[STB_ESB] == |(esr_reg & enab_reg))
    else $error("summary bit wrong");
  mav_flag_a: assert property (TX_VALID_OUT |-> STB_OUT[STB_MAV])
    else $error("valid byte without message available");
  talk_stall_a: assert property (TALK_IN && !STB_OUT[STB_MAV] |->
    !TX_VALID_OUT) else $error("talker not stalled");
  qerr_set_a: assert property (CE_IN && qerr |=> esr_reg[EV_QRY])
    else $error("query error not flagged");
  err_push_a: assert property (CE_IN && e_push && !e_full && !e_pop |=>
    e_count == $past(e_count) + 1'b1)
    else $error("error entry not queued");
  err_empty_a: assert property (CE_IN && e_pop && e_empty |=>
    fid_reg == ID_NOERR && !fneg_reg && fst_reg == F_SIGN)
    else $error("empty error query not no-error");
endmodule

// ### bus_ctrl_model.sv
// bus controller as listener: addresses the device to talk, takes bytes
// assumes the bench asks for talk off the clock edge; slow halves the rate
`timescale 1ns/1ps
module bus_ctrl_model (
  // clock
  input wire logic clk_in,
  // bench control
  input wire logic talk_req_in,
  input wire logic slow_in,
  // device side
  output logic talk_out,
  output logic tx_ready_out
);
  logic talk_q = 1'b0;
  logic phase_reg = 1'b0;
  logic ready_reg = 1'b0;
  assign talk_out = talk_req_in;
  assign tx_ready_out = ready_reg;
  always @(posedge clk_in) begin
    talk_q <= talk_req_in;
  end
  // acceptance changes off the sampling edge, only while addressed
  always @(negedge clk_in) begin
    phase_reg <= ~phase_reg;
    ready_reg <= talk_q && (!slow_in || phase_reg);
  end
endmodule

// ### ieee_status_event_queues_tb.sv
// self-checking bench for the status and queue block
// assumes the listener model in bus_ctrl_model and the status package
`timescale 1ns/1ps
module ieee_status_event_queues_tb
  import ieee_status_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic signed [31:0] cmd_arg = 32'sh0;
  logic [7:0] evt_set = 8'h00;
  logic pending = 1'b1;
  logic talk_req = 1'b0;
  logic slow = 1'b0;
  logic cmd_ready, talk, tx_valid, tx_ready;
  logic [7:0] tx_data, stb, esr, enab;
  logic [7:0] rx_q[$];
  int bad_count = 0;
  int tests_run = 0;

  always #2.5 clk = ~clk;

  ieee_status_event_queues u_ieee_status_event_queues (
    .CLK_IN(clk), .RESET_IN(rst), .CE_IN(ce),
    .CMD_VALID_IN(cmd_valid), .CMD_OP_IN(cmd_op), .CMD_ARG_IN(cmd_arg),
    .CMD_READY_OUT(cmd_ready), .EVT_SET_IN(evt_set),
    .PENDING_IN(pending), .TALK_IN(talk), .TX_DATA_OUT(tx_data),
    .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready), .STB_OUT(stb),
    .ESR_OUT(esr), .ENAB_OUT(enab)
  );

  bus_ctrl_model u_bus_ctrl_model (
    .clk_in(clk), .talk_req_in(talk_req), .slow_in(slow),
    .talk_out(talk), .tx_ready_out(tx_ready)
  );

  always @(posedge clk) begin
    if (tx_valid && tx_ready && ce) begin
      rx_q.push_back(tx_data);
    end
  end

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                        input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  task automatic check_reply(input string exp);
    tests_run++;
    if (rx_q.size() != exp.len()) begin
      bad_count++;
      $display("wrong value at %0t: reply length %0d", $time, rx_q.size());
      return;
    end
    foreach (rx_q[i]) begin
      if (rx_q[i] !== exp[i]) begin
        bad_count++;
        $display("wrong value at %0t: reply byte %0d", $time, i);
        return;
      end
    end
  endtask

  // command held until taken, released after the taking edge
  task automatic send(input logic [2:0] op, input int arg);
    int n;
    n = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_arg = arg;
    while (cmd_ready !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) begin
      bad_count++;
      $display("wrong value at %0t: command never taken", $time);
    end
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask

  task automatic pulse(input logic [7:0] bits);
    @(negedge clk);
    evt_set = bits;
    @(negedge clk);
    evt_set = 8'h00;
  endtask

  task automatic query(input logic [2:0] op, input string exp,
                       input bit early);
    int n;
    n = 0;
    rx_q.delete();
    talk_req = early;
    send(op, 0);
    if (early) begin
      check8(tx_valid, 1'b0, "talker stall");
    end else begin
      repeat (40) @(negedge clk);
      check8(stb[STB_MAV], 1'b1, "mav set");
      if (exp.len() > OUTQ_DEPTH) begin
        check8(cmd_ready, 1'b0, "full queue");
      end
    end
    talk_req = 1'b1;
    while ((rx_q.size() == 0 || rx_q[$] !== CH_LF) && n < 1000) begin
      @(negedge clk);
      n++;
    end
    talk_req = 1'b0;
    if (n >= 1000) begin
      bad_count++;
      $display("wrong value at %0t: reply never ended", $time);
    end
    check8(stb[STB_MAV], 1'b0, "mav clear");
    check_reply(exp);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop;
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    check8(enab, ENAB_RST, "enab reset");
    check8(esr, ESR_RST, "esr reset");
    check8(stb, 8'h00, "stb reset");
    check8(cmd_ready, 1'b1, "ready reset");
    send(OP_ENAB_WR, 36);
    check8(enab, 8'd36, "enab write");
    query(OP_ENAB_RD, "36\n", 1'b1);
    pulse(8'h20);
    check8(esr, 8'h20, "cmd error");
    check8(stb, 8'h20, "summary");
    send(OP_ENAB_WR, 0);
    check8(enab, 8'h00, "enab zero");
    check8(stb, 8'h00, "summary off");
    send(OP_ENAB_WR, 255);
    send(OP_ENAB_WR, 256);
    send(OP_ENAB_WR, -1);
    check8(enab, 8'hff, "enab kept");
    check8(esr, 8'h30, "range error");
    check8(stb, 8'h20, "summary on");
    query(OP_ESR_RD, "48\n", 1'b0);
    check8(esr, 8'h00, "esr cleared");
    check8(stb, 8'h00, "summary cleared");
    query(OP_ERR_RD, "-100,\"Command error\"\n", 1'b0);
    query(OP_ERR_RD, "-222,\"Data out of range\"\n", 1'b0);
    query(OP_ERR_RD, "+0,\"No error\"\n", 1'b0);
    // frozen while enable is low
    ce = 1'b0;
    pulse(8'h08);
    check8(esr, 8'h00, "frozen");
    ce = 1'b1;
    // talker with nothing pending
    pending = 1'b0;
    talk_req = 1'b1;
    repeat (6) @(negedge clk);
    talk_req = 1'b0;
    pending = 1'b1;
    check8(esr, 8'h04, "query error");
    for (int i = 0; i < 20; i++) begin
      pulse(8'h08);
      send(OP_CLS, 0);
      check8(esr, 8'h00, "clear status");
    end
    slow = 1'b1;
    query(OP_ERR_RD, "-400,\"Query error\"\n", 1'b0);
    for (int i = 0; i < 18; i++) begin
      query(OP_ERR_RD, "-300,\"Device-specific error\"\n", 1'b0);
    end
    query(OP_ERR_RD, "-350,\"Queue overflow\"\n", 1'b0);
    query(OP_ERR_RD, "+0,\"No error\"\n", 1'b0);
    report_and_stop;
  end
endmodule
